// ### src/caf_defs.vh
// Register map, field positions and reset values of the acceptance filter block
`ifndef CAF_DEFS_VH
`define CAF_DEFS_VH

// ====================================================
// Register byte offsets
`define CAF_OFS_MSEL_LO 12'h000
`define CAF_OFS_MSEL_HI 12'h004
`define CAF_OFS_FEN 12'h008
`define CAF_OFS_MASK_BASE 12'h010
`define CAF_OFS_RX_STAT 12'h030
`define CAF_OFS_FSID_BASE 12'h100
`define CAF_OFS_FEID_BASE 12'h140

// ====================================================
// Standard-identifier register layout
`define CAF_SID_HI 15
`define CAF_SID_LO 5
`define CAF_TYPE_BIT 3
`define CAF_EXH_HI 1
`define CAF_EXH_LO 0
`define CAF_SIDREG_WMASK 16'hffeb

// ====================================================
// Mask source codes, reset values and bus response codes
`define CAF_MSRC_NONE 2'h3
`define CAF_MSEL_RST 16'h0000
`define CAF_FEN_RST 16'hffff
`define CAF_AXI_OKAY 2'h0
`define CAF_AXI_SLVERR 2'h2

`endif

// ### src/caf_match_unit.v
// One acceptance filter comparator
`timescale 1ns/1ns
module caf_match_unit (
   // Filter contents
   input wire [15:0] fsid_in,
   input wire [15:0] feid_in,
   input wire enable_in,
   // Selected mask, all identifier bits one and the type bit zero when none applies
   input wire [15:0] msid_in,
   input wire [15:0] meid_in,
   // Received frame
   input wire [10:0] rx_sid_in,
   input wire [17:0] rx_eid_in,
   input wire rx_ext_in,
   // Result
   output wire hit_out
);
`include "caf_defs.vh"
   wire [28:0] fbits;
   wire [28:0] mbits;
   wire [28:0] rbits;
   wire id_ok;
   wire type_ok;
   wire type_match_enable;
   wire filter_frame_type_select;

   // Identifier bits: standard plus the 18 extended bits
   assign fbits = {fsid_in[`CAF_SID_HI:`CAF_SID_LO], fsid_in[`CAF_EXH_HI:`CAF_EXH_LO], feid_in};
   assign mbits = {msid_in[`CAF_SID_HI:`CAF_SID_LO], msid_in[`CAF_EXH_HI:`CAF_EXH_LO], meid_in};
   assign rbits = {rx_sid_in, rx_eid_in};
   // Mask one selects bit for comparison, zero is don't-care
   assign id_ok = ((fbits ^ rbits) & mbits) == 29'h0000000;
   assign type_match_enable = msid_in[`CAF_TYPE_BIT];
   assign filter_frame_type_select = fsid_in[`CAF_TYPE_BIT];
   // Frame type only checked while the mask asks for it
   assign type_ok = !type_match_enable || (filter_frame_type_select == rx_ext_in);
   assign hit_out = enable_in && id_ok && type_ok;
endmodule // caf_match_unit

// ### src/caf_filter_top.v
// Acceptance filter bank with AXI4-Lite register access
`timescale 1ns/1ns
module caf_filter_top #(
   parameter NFILT = 16
) (
   // Clock and reset
   input wire CORE_CLK_IN,
   input wire SYS_RST_IN,
   // AXI4-Lite write address and data
   input wire [11:0] S_AXI_AWADDR_IN,
   input wire S_AXI_AWVALID_IN,
   output reg S_AXI_AWREADY_OUT,
   input wire [31:0] S_AXI_WDATA_IN,
   input wire [3:0] S_AXI_WSTRB_IN,
   input wire S_AXI_WVALID_IN,
   output reg S_AXI_WREADY_OUT,
   // AXI4-Lite write response
   output reg [1:0] S_AXI_BRESP_OUT,
   output reg S_AXI_BVALID_OUT,
   input wire S_AXI_BREADY_IN,
   // AXI4-Lite read
   input wire [11:0] S_AXI_ARADDR_IN,
   input wire S_AXI_ARVALID_IN,
   output reg S_AXI_ARREADY_OUT,
   output reg [31:0] S_AXI_RDATA_OUT,
   output reg [1:0] S_AXI_RRESP_OUT,
   output reg S_AXI_RVALID_OUT,
   input wire S_AXI_RREADY_IN,
   // Received frame from the protocol engine
   input wire [10:0] RX_SID_IN,
   input wire [17:0] RX_EID_IN,
   input wire RX_EXT_IN,
   input wire RX_VALID_IN,
   // Match result
   output reg RX_ACCEPT_OUT,
   output reg [3:0] RX_FILTER_OUT,
   output reg RX_DONE_OUT
);
`include "caf_defs.vh"

   // ====================================================
   // Register storage
   reg [15:0] fsid_q [0:NFILT-1];
   reg [15:0] feid_q [0:NFILT-1];
   reg [15:0] msid_q [0:2];
   reg [15:0] meid_q [0:2];
   reg [15:0] msel_lo_q;
   reg [15:0] msel_hi_q;
   reg [15:0] fen_q;
   reg [3:0] last_filt_q;
   reg last_acc_q;
   reg [7:0] hit_count_q;

   // ====================================================
   // Helper functions
   // Merge a 32-bit write into a 16-bit register under byte strobes
   function [15:0] wmerge;
      input [15:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         wmerge = old;
         if (strb[0]) begin
            wmerge[7:0] = data[7:0];
         end
         if (strb[1]) begin
            wmerge[15:8] = data[15:8];
         end
      end
   endfunction

   // Mask source selector of one filter
   function [1:0] msrc;
      input [15:0] lo;
      input [15:0] hi;
      input [3:0] idx;
      begin
         if (idx[3]) begin
            msrc = hi[{idx[2:0], 1'b0} +: 2];
         end else begin
            msrc = lo[{idx[2:0], 1'b0} +: 2];
         end
      end
   endfunction

   // ====================================================
   // Comparators
   wire [NFILT-1:0] hit;
   genvar gi;
   generate
      for (gi = 0; gi < NFILT; gi = gi + 1) begin : g_filt
         wire [1:0] src;
         wire [15:0] ms;
         wire [15:0] me;
         // Constant copy of the loop index, since a genvar takes no part-select
         localparam [3:0] FIDX = gi;
         assign src = msrc(msel_lo_q, msel_hi_q, FIDX);
         // Code 11 compares every identifier bit but never the frame type
         assign ms = (src == `CAF_MSRC_NONE) ? `CAF_SIDREG_WMASK & ~16'h0008 : msid_q[src];
         assign me = (src == `CAF_MSRC_NONE) ? 16'hffff : meid_q[src];
         caf_match_unit u_match (
            .fsid_in(fsid_q[gi]),
            .feid_in(feid_q[gi]),
            .enable_in(fen_q[gi]),
            .msid_in(ms),
            .meid_in(me),
            .rx_sid_in(RX_SID_IN),
            .rx_eid_in(RX_EID_IN),
            .rx_ext_in(RX_EXT_IN),
            .hit_out(hit[gi])
         );
      end
   endgenerate

   // Lowest numbered hitting filter wins
   reg [3:0] first_hit;
   integer k;
   always @* begin
      first_hit = 4'h0;
      for (k = NFILT - 1; k >= 0; k = k - 1) begin
         if (hit[k]) begin
            first_hit = k[3:0];
         end
      end
   end

   // Result registered one cycle after the frame strobe
   always @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         RX_ACCEPT_OUT <= 1'b0;
         RX_FILTER_OUT <= 4'h0;
         RX_DONE_OUT <= 1'b0;
         last_filt_q <= 4'h0;
         last_acc_q <= 1'b0;
         hit_count_q <= 8'h00;
      end else begin
         RX_DONE_OUT <= RX_VALID_IN;
         RX_ACCEPT_OUT <= RX_VALID_IN && (hit != {NFILT{1'b0}});
         RX_FILTER_OUT <= RX_VALID_IN ? first_hit : 4'h0;
         if (RX_VALID_IN) begin
            last_acc_q <= (hit != {NFILT{1'b0}});
            last_filt_q <= first_hit;
            if (hit != {NFILT{1'b0}}) begin
               hit_count_q <= hit_count_q + 8'h01;
            end
         end
      end
   end

   // ====================================================
   // AXI4-Lite write channel: address and data taken in either order
   reg [11:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg aw_have_q;
   reg w_have_q;
   wire do_write;
   wire [11:0] wa;
   wire [3:0] widx;
   assign do_write = aw_have_q && w_have_q && !S_AXI_BVALID_OUT;
   assign wa = awaddr_q;
   assign widx = wa[5:2];

   // Decode of a word address to a valid register
   function addr_ok;
      input [11:0] a;
      begin
         addr_ok = (a[1:0] == 2'h0) && (
            (a == `CAF_OFS_MSEL_LO) || (a == `CAF_OFS_MSEL_HI) ||
            (a == `CAF_OFS_FEN) || (a == `CAF_OFS_RX_STAT) ||
            ((a >= `CAF_OFS_MASK_BASE) && (a < `CAF_OFS_MASK_BASE + 12'h018)) ||
            ((a >= `CAF_OFS_FSID_BASE) && (a < `CAF_OFS_FSID_BASE + 12'h040)) ||
            ((a >= `CAF_OFS_FEID_BASE) && (a < `CAF_OFS_FEID_BASE + 12'h040)));
      end
   endfunction

   wire [11:0] mofs;
   wire [1:0] mset;
   assign mofs = wa - `CAF_OFS_MASK_BASE;
   assign mset = mofs[4:3];
   // Refused writes (unaligned or unmapped) must not reach the storage
   wire wr_ok;
   assign wr_ok = do_write && addr_ok(wa);

   // Identifier registers are left unreset on purpose
   always @(posedge CORE_CLK_IN) begin
      if (wr_ok && wa >= `CAF_OFS_FSID_BASE && wa < `CAF_OFS_FSID_BASE + 12'h040) begin
         fsid_q[widx] <= wmerge(fsid_q[widx], wdata_q, wstrb_q) & `CAF_SIDREG_WMASK;
      end
      if (wr_ok && wa >= `CAF_OFS_FEID_BASE && wa < `CAF_OFS_FEID_BASE + 12'h040) begin
         feid_q[widx] <= wmerge(feid_q[widx], wdata_q, wstrb_q);
      end
      if (wr_ok && wa >= `CAF_OFS_MASK_BASE && wa < `CAF_OFS_MASK_BASE + 12'h018) begin
         if (mofs[2] == 1'b0) begin
            msid_q[mset] <= wmerge(msid_q[mset], wdata_q, wstrb_q) & `CAF_SIDREG_WMASK;
         end else begin
            meid_q[mset] <= wmerge(meid_q[mset], wdata_q, wstrb_q);
         end
      end
   end

   // Selector, enable registers and write handshake
   always @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         msel_lo_q <= `CAF_MSEL_RST;
         msel_hi_q <= `CAF_MSEL_RST;
         fen_q <= `CAF_FEN_RST;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         S_AXI_AWREADY_OUT <= 1'b0;
         S_AXI_WREADY_OUT <= 1'b0;
         S_AXI_BVALID_OUT <= 1'b0;
         S_AXI_BRESP_OUT <= `CAF_AXI_OKAY;
      end else begin
         S_AXI_AWREADY_OUT <= !aw_have_q && !S_AXI_AWREADY_OUT && S_AXI_AWVALID_IN;
         S_AXI_WREADY_OUT <= !w_have_q && !S_AXI_WREADY_OUT && S_AXI_WVALID_IN;
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_have_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR_IN;
         end
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_have_q <= 1'b1;
            wdata_q <= S_AXI_WDATA_IN;
            wstrb_q <= S_AXI_WSTRB_IN;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT <= addr_ok(wa) ? `CAF_AXI_OKAY : `CAF_AXI_SLVERR;
            if (wa == `CAF_OFS_MSEL_LO) begin
               msel_lo_q <= wmerge(msel_lo_q, wdata_q, wstrb_q);
            end
            if (wa == `CAF_OFS_MSEL_HI) begin
               msel_hi_q <= wmerge(msel_hi_q, wdata_q, wstrb_q);
            end
            if (wa == `CAF_OFS_FEN) begin
               fen_q <= wmerge(fen_q, wdata_q, wstrb_q);
            end
         end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
         end
      end
   end

   // ====================================================
   // AXI4-Lite read channel, data formed from the decoded address
   reg [31:0] rd_word;
   wire [11:0] ra;
   wire [11:0] rmofs;
   assign ra = S_AXI_ARADDR_IN;
   assign rmofs = ra - `CAF_OFS_MASK_BASE;
   always @* begin
      rd_word = 32'h00000000;
      if (ra == `CAF_OFS_MSEL_LO) begin
         rd_word = {16'h0000, msel_lo_q};
      end else if (ra == `CAF_OFS_MSEL_HI) begin
         rd_word = {16'h0000, msel_hi_q};
      end else if (ra == `CAF_OFS_FEN) begin
         rd_word = {16'h0000, fen_q};
      end else if (ra == `CAF_OFS_RX_STAT) begin
         rd_word = {16'h0000, hit_count_q, 3'h0, last_acc_q, last_filt_q};
      end else if (ra >= `CAF_OFS_MASK_BASE && ra < `CAF_OFS_MASK_BASE + 12'h018) begin
         rd_word = {16'h0000, rmofs[2] ? meid_q[rmofs[4:3]] : msid_q[rmofs[4:3]]};
      end else if (ra >= `CAF_OFS_FSID_BASE && ra < `CAF_OFS_FSID_BASE + 12'h040) begin
         rd_word = {16'h0000, fsid_q[ra[5:2]] & `CAF_SIDREG_WMASK};
      end else if (ra >= `CAF_OFS_FEID_BASE && ra < `CAF_OFS_FEID_BASE + 12'h040) begin
         rd_word = {16'h0000, feid_q[ra[5:2]]};
      end
   end

   always @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
         S_AXI_ARREADY_OUT <= 1'b0;
         S_AXI_RVALID_OUT <= 1'b0;
         S_AXI_RDATA_OUT <= 32'h00000000;
         S_AXI_RRESP_OUT <= `CAF_AXI_OKAY;
      end else begin
         S_AXI_ARREADY_OUT <= !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT && S_AXI_ARVALID_IN;
         if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RDATA_OUT <= addr_ok(ra) ? rd_word : 32'h00000000;
            S_AXI_RRESP_OUT <= addr_ok(ra) ? `CAF_AXI_OKAY : `CAF_AXI_SLVERR;
         end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
         end
      end
   end
endmodule // caf_filter_top

// ### tb/caf_filter_asserts.sv
// Port-level checks for the acceptance filter bank
`timescale 1ns/1ns
module caf_filter_asserts (
   // Clock and reset
   input wire CORE_CLK_IN,
   input wire SYS_RST_IN,
   // Register bus
   input wire S_AXI_AWREADY_OUT,
   input wire S_AXI_BVALID_OUT,
   input wire S_AXI_BREADY_IN,
   input wire [11:0] S_AXI_ARADDR_IN,
   input wire S_AXI_ARVALID_IN,
   input wire S_AXI_ARREADY_OUT,
   input wire [31:0] S_AXI_RDATA_OUT,
   input wire S_AXI_RVALID_OUT,
   input wire S_AXI_RREADY_IN,
   // Match path
   input wire RX_VALID_IN,
   input wire RX_ACCEPT_OUT,
   input wire [3:0] RX_FILTER_OUT,
   input wire RX_DONE_OUT
);
   reg [11:0] rd_addr_q;
   // Address of the read under way, so read data can be judged by target
   always @(posedge CORE_CLK_IN) begin
      if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
         rd_addr_q <= S_AXI_ARADDR_IN;
   end
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   // ====================================================
   // Match result timing and encoding
   AST_DONE_LAT: assert property (RX_VALID_IN |=> RX_DONE_OUT)
      else $error("no result after frame");
   AST_DONE_CAUSE: assert property (RX_DONE_OUT |-> $past(RX_VALID_IN))
      else $error("result without frame");
   AST_ACC_DONE: assert property (RX_ACCEPT_OUT |-> RX_DONE_OUT)
      else $error("accept outside result cycle");
   AST_MISS_IDX: assert property (RX_DONE_OUT && !RX_ACCEPT_OUT |-> RX_FILTER_OUT == 4'h0)
      else $error("index set on miss");
   // ====================================================
   // Register bus
   AST_UNIMP_ZERO: assert property (S_AXI_RVALID_OUT && rd_addr_q[11:6] == 6'h04
      |-> !S_AXI_RDATA_OUT[4] && !S_AXI_RDATA_OUT[2])
      else $error("unimplemented bits read nonzero");
   AST_RD_HIGH: assert property (S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:16] == 16'h0000)
      else $error("upper read bits nonzero");
   AST_RD_LAT: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
      else $error("read answer late");
   AST_RD_HOLD: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
      |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
      else $error("read data dropped");
   AST_B_HOLD: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
      else $error("write response dropped");
   AST_AW_PULSE: assert property (S_AXI_AWREADY_OUT |=> !S_AXI_AWREADY_OUT)
      else $error("address ready held");
   // Main scenarios reached
   C_ACCEPT: cover property (RX_ACCEPT_OUT);
   C_MISS: cover property (RX_DONE_OUT && !RX_ACCEPT_OUT);
   C_BACK: cover property (RX_VALID_IN ##1 RX_VALID_IN);
endmodule // caf_filter_asserts

// ### tb/caf_rx_engine.sv
// Behavioural protocol engine handing received identifiers to the filter
`timescale 1ns/1ns
module caf_rx_engine (
   // Clock and request from the bench
   input wire clk_in,
   input wire go_in,
   input wire [29:0] frm_in,
   // Identifier bus towards the filter
   output reg [10:0] sid_out = 11'h000,
   output reg [17:0] eid_out = 18'h00000,
   output reg ext_out = 1'b0,
   output reg valid_out = 1'b0
);
   // Ids stand in the valid cycle; between frames the bus inverts itself every
   // cycle, so the last id shows again every second cycle while valid is low
   always @(posedge clk_in) begin
      valid_out <= go_in;
      if (go_in)
         {ext_out, sid_out, eid_out} <= frm_in;
      else
         {ext_out, sid_out, eid_out} <= ~{ext_out, sid_out, eid_out};
   end
endmodule // caf_rx_engine

// ### tb/tb_can_acceptance_filter_match.sv
// Self-checking bench for the acceptance filter bank
`timescale 1ns/1ns
module tb_can_acceptance_filter_match;
   logic CORE_CLK_IN = 0, SYS_RST_IN = 1;
   logic [11:0] S_AXI_AWADDR_IN = 0, S_AXI_ARADDR_IN = 0;
   logic [31:0] S_AXI_WDATA_IN = 0, S_AXI_RDATA_OUT;
   logic [3:0] S_AXI_WSTRB_IN = 4'hf, RX_FILTER_OUT;
   logic S_AXI_AWVALID_IN = 0, S_AXI_WVALID_IN = 0, S_AXI_BREADY_IN = 0;
   logic S_AXI_ARVALID_IN = 0, S_AXI_RREADY_IN = 0, RX_ACCEPT_OUT, RX_DONE_OUT;
   logic S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
   logic S_AXI_RVALID_OUT, go = 0, late_rdy = 0;
   logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
   logic [29:0] frm = 0;
   wire [10:0] RX_SID_IN;
   wire [17:0] RX_EID_IN;
   wire RX_EXT_IN, RX_VALID_IN;
   int n_errors = 0, checks = 0, cyc = 0, i;
   // Setup writes: address, then data (masks, filters, selectors, enables)
   logic [27:0] cfg [17] = '{28'h010ffeb, 28'h014ffff, 28'h0180000, 28'h01c0000,
      28'h020ffe8, 28'h0240000, 28'h100246a, 28'h140abcd, 28'h1040aa0, 28'h1440000,
      28'h108ffff, 28'h148ffff, 28'h1240000, 28'h1640000, 28'h0000038, 28'h0040004,
      28'h0080207};
   // Frames: type, std id, ext id, then accept and index expected
   logic [34:0] rows [10] = '{{1'b1, 11'h123, 18'h2abcd, 5'h10},
      {1'b0, 11'h123, 18'h2abcd, 5'h19}, {1'b1, 11'h123, 18'h2abcc, 5'h19},
      {1'b0, 11'h055, 18'h00000, 5'h11}, {1'b0, 11'h055, 18'h3ffff, 5'h11},
      {1'b1, 11'h055, 18'h00000, 5'h19}, {1'b0, 11'h7ff, 18'h3ffff, 5'h12},
      {1'b1, 11'h7ff, 18'h3ffff, 5'h12}, {1'b1, 11'h7fe, 18'h3ffff, 5'h19},
      {1'b0, 11'h054, 18'h00000, 5'h19}};
   caf_filter_top uut (.*);
   caf_rx_engine u_eng (.clk_in(CORE_CLK_IN), .go_in(go), .frm_in(frm),
      .sid_out(RX_SID_IN), .eid_out(RX_EID_IN), .ext_out(RX_EXT_IN),
      .valid_out(RX_VALID_IN));
   initial forever #25 CORE_CLK_IN = ~CORE_CLK_IN;
   // ====================================================
   // Shared tasks
   task close_out;
      begin
         $display("checks %0d mismatches %0d", checks, n_errors);
         if (n_errors == 0 && checks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // Response ready goes up with the request; late_rdy holds it back until
   // the answer shows, so the slave must keep its answer standing
   task wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
      logic ta, tw, got;
      begin
         S_AXI_AWADDR_IN <= a;
         S_AXI_WDATA_IN <= {16'h0000, d};
         S_AXI_AWVALID_IN <= 1;
         S_AXI_WVALID_IN <= 1;
         S_AXI_BREADY_IN <= !late_rdy;
         ta = 0;
         tw = 0;
         got = 0;
         while (!(ta && tw)) begin
            @(posedge CORE_CLK_IN);
            ta = ta | S_AXI_AWREADY_OUT;
            tw = tw | S_AXI_WREADY_OUT;
            S_AXI_AWVALID_IN <= !ta;
            S_AXI_WVALID_IN <= !tw;
         end
         while (!got) begin
            @(posedge CORE_CLK_IN);
            got = S_AXI_BVALID_OUT && S_AXI_BREADY_IN;
            if (!got && S_AXI_BVALID_OUT)
               S_AXI_BREADY_IN <= 1;
         end
         chk("bresp", er, S_AXI_BRESP_OUT);
         S_AXI_BREADY_IN <= 0;
         @(posedge CORE_CLK_IN);
      end
   endtask
   task rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic got;
      begin
         S_AXI_ARADDR_IN <= a;
         S_AXI_ARVALID_IN <= 1;
         S_AXI_RREADY_IN <= !late_rdy;
         got = 0;
         @(posedge CORE_CLK_IN);
         while (!S_AXI_ARREADY_OUT) @(posedge CORE_CLK_IN);
         S_AXI_ARVALID_IN <= 0;
         while (!got) begin
            @(posedge CORE_CLK_IN);
            got = S_AXI_RVALID_OUT && S_AXI_RREADY_IN;
            if (!got && S_AXI_RVALID_OUT)
               S_AXI_RREADY_IN <= 1;
         end
         chk("rdata", ed, S_AXI_RDATA_OUT);
         chk("rresp", er, S_AXI_RRESP_OUT);
         S_AXI_RREADY_IN <= 0;
         @(posedge CORE_CLK_IN);
      end
   endtask
   task res(input logic [4:0] r);
      begin
         chk("done", 1, RX_DONE_OUT);
         chk("accept", r[4], RX_ACCEPT_OUT);
         chk("filter", r[3:0], RX_FILTER_OUT);
      end
   endtask
   task frame(input logic [34:0] r);
      begin
         @(posedge CORE_CLK_IN);
         go <= 1;
         frm <= r[34:5];
         @(posedge CORE_CLK_IN);
         go <= 0;
         @(posedge CORE_CLK_IN);
         #1;
         res(r[4:0]);
      end
   endtask
   // Cycle ceiling cuts a hung handshake short
   always @(posedge CORE_CLK_IN) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors = n_errors + 1;
         close_out;
      end
   end
   // ====================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge CORE_CLK_IN);
      SYS_RST_IN <= 0;
      rd_chk(12'h000, 0, 0);
      rd_chk(12'h004, 0, 0);
      rd_chk(12'h008, 32'hffff, 0);
      $display("test reset done");
      for (i = 0; i < 17; i++)
         wr(cfg[i][27:16], cfg[i][15:0], 2'h0);
      wr(12'h0f0, 16'h1234, 2'h2);
      rd_chk(12'h0f0, 0, 2'h2);
      rd_chk(12'h108, 32'hffeb, 0);
      rd_chk(12'h100, 32'h246a, 0);
      rd_chk(12'h000, 32'h0038, 0);
      rd_chk(12'h004, 32'h0004, 0);
      $display("test registers done");
      for (i = 0; i < 10; i++)
         frame(rows[i]);
      $display("test match table done");
      @(posedge CORE_CLK_IN);
      go <= 1;
      frm <= rows[0][34:5];
      @(posedge CORE_CLK_IN);
      frm <= rows[3][34:5];
      @(posedge CORE_CLK_IN);
      go <= 0;
      #1;
      res(rows[0][4:0]);
      @(posedge CORE_CLK_IN);
      #1;
      res(rows[3][4:0]);
      wr(12'h008, 16'h0007, 0);
      frame({rows[8][34:5], 5'h00});
      wr(12'h008, 16'h0207, 0);
      wr(12'h004, 16'h000c, 0);
      frame({1'b0, 11'h001, 18'h00000, 5'h00});
      frame({1'b1, 11'h000, 18'h00000, 5'h19});
      // Late ready on both answers; status holds 13 hits, last on filter 9
      late_rdy = 1;
      wr(12'h00c, 16'h0000, 2'h2);
      rd_chk(12'h030, 32'h0d19, 0);
      late_rdy = 0;
      $display("test awkward cases done");
      close_out;
   end
endmodule // tb_can_acceptance_filter_match
bind caf_filter_top caf_filter_asserts u_chk (.*);
